/* File: common/intc_pkg.sv */
package intc_pkg;

  // ****************************************************************
  // register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] OFS_REQUEST_FLAG      = 8'h00;
  localparam logic [7:0] OFS_REQUEST_ENABLE    = 8'h04;
  localparam logic [7:0] OFS_SOURCE_PRIORITY   = 8'h08;
  localparam logic [7:0] OFS_INTERRUPT_CONTROL_ONE = 8'h0c;
  localparam logic [7:0] OFS_INTERRUPT_CONTROL_TWO = 8'h10;
  localparam logic [7:0] OFS_PROCESSOR_STATUS  = 8'h14;
  localparam logic [7:0] OFS_CORE_CONTROL      = 8'h18;
  localparam logic [7:0] OFS_DISPATCH_STATE    = 8'h1c;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int         NESTING_DISABLE_POS   = 15;
  localparam int         CPU_PRIORITY_LSB      = 5;
  localparam int         LEVEL_BIT3_POS        = 3;
  localparam int         PRIO_FIELD_STRIDE     = 4;
  localparam logic [2:0] PRIORITY_MASK_ALL     = 3'h7;
  localparam logic [2:0] PRIORITY_RESET        = 3'h0;
  localparam logic [2:0] SOURCE_PRIO_RESET     = 3'h4;
  localparam logic [1:0] RETURN_RESTORE_CYCLE  = 2'h1;
  localparam logic [1:0] RETURN_LAST_CYCLE     = 2'h3;

  localparam int PC_W  = 24;
  localparam int VEC_W = 7;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_FINISH = 6'h02,
    ST_SAVE   = 6'h04,
    ST_VECTOR = 6'h08,
    ST_LOAD   = 6'h10,
    ST_RETURN = 6'h20
  } disp_state_t;

  typedef struct packed {
    logic             found;
    logic [VEC_W-1:0] idx;
    logic [2:0]       level;
  } win_t;

  // signals from the processor core, same clock
  typedef struct packed {
    logic            instr_last;
    logic            extra_stall;
    logic            return_start;
    logic [PC_W-1:0] pc;
    logic [7:0]      status_low;
    logic [PC_W-1:0] isr_addr;
    logic [PC_W-1:0] pop_pc;
    logic [7:0]      pop_status_low;
    logic            pop_level_bit3;
  } core_in_t;

  // signals to the processor core
  typedef struct packed {
    logic             nop_slot;
    logic             push_valid;
    logic [PC_W-1:0]  push_pc;
    logic [7:0]       push_status_low;
    logic             push_level_bit3;
    logic             vec_fetch;
    logic [VEC_W-1:0] vector_num;
    logic             pc_load;
    logic [PC_W-1:0]  pc_value;
    logic             resume;
  } core_out_t;

endpackage : intc_pkg

/* File: verilog/ext_edge_detect.sv */
`timescale 1ns/100ps
module ext_edge_detect
  import intc_pkg::*;
#(
  parameter int N = 3
)(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic [N-1:0] pin,
  input  wire logic [N-1:0] falling_sel,
  output logic      [N-1:0] edge_pulse
);

  // ****************************************************************
  // two-stage synchroniser, then one stage of history
  // ****************************************************************
  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] prev_r;
  logic [2:0]   primed_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      primed_r <= 3'h0;
    end
    else if (ce)
    begin
      primed_r <= {primed_r[1:0], 1'b1};
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // polarity bit low selects rising, high selects falling; no edge until
  // the history holds real pin samples, so a pin idling high after reset
  // gives no false edge
  always_comb
  begin
    for (int i = 0; i < N; i++)
      edge_pulse[i] = primed_r[2] &
                      (falling_sel[i] ? (prev_r[i] & ~sync_r[i])
                                      : (~prev_r[i] & sync_r[i]));
  end

endmodule : ext_edge_detect

/* File: verilog/interrupt_dispatch_nesting.sv */
`timescale 1ns/100ps
module interrupt_dispatch_nesting
  import intc_pkg::*;
#(
  parameter int NUM_SRC = 8,
  parameter int NUM_EXT = 3
)(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               ce,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic [NUM_SRC-1:0] periph_req,
  input  wire logic [NUM_EXT-1:0] ext_pin,
  input  wire core_in_t           core_i,
  output core_out_t               core_o,
  output logic                    wake,
  output logic                    conv_request
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [NUM_SRC-1:0]       request_flag_regs_r;
  logic [NUM_SRC-1:0]       request_enable_regs_r;
  logic [NUM_SRC-1:0][2:0]  source_prio_r;
  logic                     nesting_disable_r;
  logic [NUM_EXT-1:0]       ext_edge_polarity_sel_r;
  logic [2:0]               cpu_priority_field_r;
  logic [7:0]               status_low_r;
  logic                     priority_level_bit3_r;
  disp_state_t              state_r;
  disp_state_t              state_nxt;
  win_t                     acc_r;
  logic                     stall_r;
  logic [1:0]               ret_cnt_r;
  logic [NUM_EXT-1:0]       ext_edge;
  logic                     wr_pend_r;
  logic [7:0]               wr_addr_r;
  logic [7:0]               rd_addr_r;
  win_t                     win;
  logic [NUM_SRC-1:0]       active;
  logic                     beats;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // fixed order inside a level: scanning upward and taking only a
  // strictly higher level leaves ties with the lowest vector
  function automatic win_t pick_winner(
    input logic [NUM_SRC-1:0]      req,
    input logic [NUM_SRC-1:0][2:0] prio
  );
    win_t w;
    w = '0;
    for (int i = 0; i < NUM_SRC; i++)
      if (req[i] && prio[i] > w.level)
      begin
        w.found = 1'b1;
        w.idx   = VEC_W'(i);
        w.level = prio[i];
      end
    return w;
  endfunction : pick_winner

  function automatic logic wr_hit(input logic [7:0] ofs);
    return wr_pend_r && (wr_addr_r == ofs);
  endfunction : wr_hit

  // ****************************************************************
  // external pins
  // ****************************************************************
  ext_edge_detect #(
    .N           (NUM_EXT)
  ) u_edge (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .ce          (ce),
    .pin         (ext_pin),
    .falling_sel (ext_edge_polarity_sel_r),
    .edge_pulse  (ext_edge)
  );

  // ****************************************************************
  // arbitration
  // ****************************************************************
  // level 0 never beats anything, so it is effectively disabled
  assign active = request_flag_regs_r & request_enable_regs_r;
  assign win    = pick_winner(active, source_prio_r);
  // bit 3 set means trap level, above every user level
  assign beats  = win.found && !priority_level_bit3_r &&
                  (win.level > cpu_priority_field_r);

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // reads take one wait state so that a write just before them lands first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rd_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end
    else if (ce)
    begin
      wr_pend_r <= hsel && htrans[1] && hready && hwrite;
      wr_addr_r <= haddr[7:0];
      hresp     <= 1'b0;
      if (!hreadyout)
      begin
        hreadyout <= 1'b1;
        unique case (rd_addr_r)
          OFS_REQUEST_FLAG:
            hrdata <= 32'(request_flag_regs_r);
          OFS_REQUEST_ENABLE:
            hrdata <= 32'(request_enable_regs_r);
          OFS_SOURCE_PRIORITY:
          begin
            hrdata <= 32'h0000_0000;
            for (int i = 0; i < NUM_SRC; i++)
              hrdata[i*PRIO_FIELD_STRIDE +: 3] <= source_prio_r[i];
          end
          OFS_INTERRUPT_CONTROL_ONE:
            hrdata <= 32'(nesting_disable_r) << NESTING_DISABLE_POS;
          OFS_INTERRUPT_CONTROL_TWO:
            hrdata <= 32'(ext_edge_polarity_sel_r);
          OFS_PROCESSOR_STATUS:
            hrdata <= 32'({cpu_priority_field_r, status_low_r[4:0]});
          OFS_CORE_CONTROL:
            hrdata <= 32'(priority_level_bit3_r) << LEVEL_BIT3_POS;
          OFS_DISPATCH_STATE:
            hrdata <= {14'h0000, state_r, win.found, win.level, win.idx,
                       1'b0};
          default:
            hrdata <= 32'h0000_0000;
        endcase
      end
      else if (hsel && htrans[1] && hready && !hwrite)
      begin
        hreadyout <= 1'b0;
        rd_addr_r <= haddr[7:0];
      end
    end
  end

  // ****************************************************************
  // request flags and control registers
  // ****************************************************************
  // a hardware set in the same cycle as a software write wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      request_flag_regs_r <= '0;
    else if (ce)
      request_flag_regs_r <= (wr_hit(OFS_REQUEST_FLAG) ?
                              hwdata[NUM_SRC-1:0] : request_flag_regs_r)
                             | periph_req
                             | NUM_SRC'(ext_edge);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      request_enable_regs_r   <= '0;
      source_prio_r           <= {NUM_SRC{SOURCE_PRIO_RESET}};
      nesting_disable_r       <= 1'b0;
      ext_edge_polarity_sel_r <= '0;
    end
    else if (ce)
    begin
      if (wr_hit(OFS_REQUEST_ENABLE))
        request_enable_regs_r <= hwdata[NUM_SRC-1:0];
      if (wr_hit(OFS_SOURCE_PRIORITY))
        for (int i = 0; i < NUM_SRC; i++)
          source_prio_r[i] <= hwdata[i*PRIO_FIELD_STRIDE +: 3];
      if (wr_hit(OFS_INTERRUPT_CONTROL_ONE))
        nesting_disable_r <= hwdata[NESTING_DISABLE_POS];
      if (wr_hit(OFS_INTERRUPT_CONTROL_TWO))
        ext_edge_polarity_sel_r <= hwdata[NUM_EXT-1:0];
    end
  end

  // ****************************************************************
  // processor level: hardware updates win over software writes
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cpu_priority_field_r  <= PRIORITY_RESET;
      status_low_r          <= 8'h00;
      priority_level_bit3_r <= 1'b0;
    end
    else if (ce)
    begin
      if (state_r == ST_SAVE && state_nxt == ST_VECTOR)
        cpu_priority_field_r <= nesting_disable_r ? PRIORITY_MASK_ALL
                                                  : acc_r.level;
      else if (state_r == ST_RETURN && ret_cnt_r == RETURN_RESTORE_CYCLE)
      begin
        cpu_priority_field_r  <= core_i.pop_status_low[7:5];
        status_low_r          <= core_i.pop_status_low;
        priority_level_bit3_r <= core_i.pop_level_bit3;
      end
      else if (wr_hit(OFS_PROCESSOR_STATUS))
      begin
        status_low_r <= hwdata[7:0];
        if (!nesting_disable_r)
          cpu_priority_field_r <= hwdata[7:5];
      end
      // the core control word has no writable bit here
    end
  end

  // ****************************************************************
  // dispatch sequencer
  // ****************************************************************
  // nesting off pins the level at 7 while in a routine, so levels
  // then decide only between requests that are pending together
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (core_i.return_start)
          state_nxt = ST_RETURN;
        else if (beats)
          state_nxt = ST_FINISH;
      ST_FINISH:
        if (core_i.instr_last)
          state_nxt = ST_SAVE;
      ST_SAVE:
        if (!stall_r)
          state_nxt = ST_VECTOR;
      ST_VECTOR:
        state_nxt = ST_LOAD;
      ST_LOAD:
        state_nxt = ST_IDLE;
      ST_RETURN:
        if (ret_cnt_r == RETURN_LAST_CYCLE)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r   <= ST_IDLE;
      acc_r     <= '0;
      stall_r   <= 1'b0;
      ret_cnt_r <= 2'h0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && state_nxt == ST_FINISH)
        acc_r <= win;
      if (state_r == ST_FINISH)
        stall_r <= core_i.extra_stall;
      else if (state_r == ST_SAVE)
        stall_r <= 1'b0;
      if (state_r == ST_RETURN)
        ret_cnt_r <= ret_cnt_r + 2'h1;
      else
        ret_cnt_r <= 2'h0;
    end
  end

  // ****************************************************************
  // core outputs, registered so each stands for its own cycle
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      core_o <= '0;
    else if (ce)
    begin
      core_o.push_valid <= state_r == ST_FINISH && state_nxt == ST_SAVE;
      core_o.nop_slot   <= state_nxt == ST_SAVE || state_nxt == ST_LOAD ||
                           (state_r == ST_RETURN &&
                            ret_cnt_r == RETURN_RESTORE_CYCLE);
      core_o.vec_fetch  <= state_nxt == ST_VECTOR &&
                           state_r == ST_SAVE;
      core_o.pc_load    <= (state_r == ST_VECTOR) ||
                           (state_r == ST_RETURN &&
                            ret_cnt_r == RETURN_RESTORE_CYCLE);
      core_o.resume     <= state_r == ST_RETURN &&
                           state_nxt == ST_IDLE;
      if (state_r == ST_FINISH && state_nxt == ST_SAVE)
      begin
        core_o.push_pc         <= core_i.pc;
        // the level bits ride in the pushed byte so the return can
        // restore the level that was current before this entry
        core_o.push_status_low <= {cpu_priority_field_r,
                                   core_i.status_low[4:0]};
        core_o.push_level_bit3 <= priority_level_bit3_r;
      end
      if (state_r == ST_SAVE)
        core_o.vector_num <= acc_r.idx;
      if (state_r == ST_VECTOR)
        core_o.pc_value <= core_i.isr_addr;
      else if (state_r == ST_RETURN && ret_cnt_r == RETURN_RESTORE_CYCLE)
        core_o.pc_value <= core_i.pop_pc;
    end
  end

  // wake ignores the cpu level; the core decides on resume or entry
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake         <= 1'b0;
      conv_request <= 1'b0;
    end
    else if (ce)
    begin
      wake         <= win.found;
      conv_request <= ext_edge[0];
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !ce);

  sequence entry_tail;
    state_r == ST_SAVE ##1 state_r == ST_VECTOR ##1 state_r == ST_LOAD
    ##1 state_r == ST_IDLE;
  endsequence

  sequence finish_now;
    state_r == ST_FINISH && core_i.instr_last && !core_i.extra_stall;
  endsequence

  a_flag_stays_set: assert property (
    |periph_req |=> (request_flag_regs_r & $past(periph_req))
                    == $past(periph_req))
    else $error("request flag lost");

  a_accept_needs_level: assert property (
    state_r == ST_IDLE ##1 state_r == ST_FINISH |->
      $past(win.level) > $past(cpu_priority_field_r))
    else $error("accepted request does not beat cpu level");

  a_entry_four_cycles: assert property (
    $rose(state_r == ST_FINISH) ##0 finish_now |=> entry_tail)
    else $error("entry did not take four cycles");

  a_context_pushed: assert property (
    state_r == ST_SAVE && $past(state_r) == ST_FINISH |->
      core_o.push_valid && core_o.nop_slot)
    else $error("context not pushed on entry");

  a_nesting_off_mask: assert property (
    state_r == ST_VECTOR && nesting_disable_r |->
      cpu_priority_field_r == 3'h7)
    else $error("cpu level not forced to 7");

  a_level_raised: assert property (
    state_r == ST_VECTOR && !nesting_disable_r |->
      cpu_priority_field_r == acc_r.level)
    else $error("cpu level not raised to accepted level");

  a_field_read_only: assert property (
    nesting_disable_r && state_r == ST_IDLE ##1 state_r == ST_IDLE |->
      $stable(cpu_priority_field_r))
    else $error("cpu level changed while nesting disabled");

  a_wake_level_zero: assert property (
    ##1 wake |-> $past(|(active & ~{NUM_SRC{1'b0}})) &&
                 $past(win.level) != 3'h0)
    else $error("wake without a source above level 0");

  a_return_restore: assert property (
    state_r == ST_RETURN && ret_cnt_r == 2'h1 |=>
      cpu_priority_field_r == $past(core_i.pop_status_low[7:5]) ##2
      core_o.resume)
    else $error("return did not restore and resume");

  a_converter_edge: assert property (
    ##1 conv_request |-> $past(ext_edge[0]))
    else $error("converter trigger without pin 0 edge");

endmodule : interrupt_dispatch_nesting

/* File: tb/core_model.sv */
`timescale 1ns/100ps
module core_model
  import intc_pkg::*;
(
  input  wire logic      hclk,
  input  wire logic      hresetn,
  input  wire logic      ret_go,
  input  wire logic      stall,
  input  wire core_out_t core_o,
  output core_in_t       core_i
);
  logic [PC_W+8:0] stk_r [8];
  logic [2:0]      sp_r;
  logic [PC_W-1:0] pc_r;

  // one-cycle instructions only; stall asks for the longer entry
  always_comb
  begin
    core_i.instr_last     = 1'b1;
    core_i.extra_stall    = stall;
    core_i.return_start   = ret_go;
    core_i.pc             = pc_r;
    core_i.status_low     = 8'h0a;
    core_i.isr_addr       = {17'h00010, core_o.vector_num};
    {core_i.pop_pc, core_i.pop_status_low, core_i.pop_level_bit3} =
      stk_r[sp_r - 3'h1];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pc_r <= '0;
      sp_r <= '0;
    end
    else
    begin
      pc_r <= core_o.pc_load ? core_o.pc_value : pc_r + 24'h1;
      if (core_o.push_valid)
      begin
        stk_r[sp_r] <= {core_o.push_pc, core_o.push_status_low,
                        core_o.push_level_bit3};
        sp_r        <= sp_r + 3'h1;
      end
      else if (core_o.resume)
        sp_r <= sp_r - 3'h1;
    end
  end
endmodule : core_model

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb
  import intc_pkg::*;
;
  logic        hclk, hresetn, hwrite, hreadyout, hresp, wake, conv;
  logic        ret_go, stall;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [7:0]  periph_req;
  logic [2:0]  ext_pin;
  core_in_t    core_i;
  core_out_t   core_o;
  int          n_fail, checks, c0, c;

  interrupt_dispatch_nesting uut (.hclk(hclk), .hresetn(hresetn),
    .ce(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .periph_req(periph_req), .ext_pin(ext_pin), .core_i(core_i),
    .core_o(core_o), .wake(wake), .conv_request(conv));
  core_model cm (.hclk(hclk), .hresetn(hresetn), .ret_go(ret_go),
    .stall(stall), .core_o(core_o), .core_i(core_i));

  initial
  begin
    hclk = 0;
    forever #50 hclk = ~hclk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string s, input logic [31:0] e, g);
    checks++;
    if (e !== g)
    begin
      n_fail++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask : chk

  task automatic step(inout int n);
    @(posedge hclk);
    n++;
    if (n > 40)
    begin
      n_fail++;
      give_verdict;
    end
  endtask : step

  // the bus never assumes a wait count, it waits for hready
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    n = 0;
    do step(n); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do step(n); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("read", e, rdv);
    chk("hresp", 0, {31'h0, hresp});
  endtask : rd

  task automatic lvl(input logic [2:0] e);
    bus(1'b0, OFS_PROCESSOR_STATUS, 32'h0);
    chk("cpu level", {29'h0, e}, {29'h0, rdv[7:5]});
  endtask : lvl

  task automatic pulse(input logic [7:0] m);
    periph_req <= m;
    @(posedge hclk);
    periph_req <= 8'h0;
  endtask : pulse

  task automatic quiet(input logic [7:0] m);
    int n;
    pulse(m);
    n = 0;
    repeat (15) @(posedge hclk) n += core_o.push_valid;
    chk("entries", 0, n);
  endtask : quiet

  // counts cycles from the flag setting to the vector fetch; a stall
  // stretches the save cycle, so the fetch is one cycle later
  task automatic enter(input logic [7:0] m, input logic [6:0] v,
                       output int k);
    k = 0;
    pulse(m);
    while (core_o.push_valid !== 1'b1) step(k);
    chk("push bit3", 0, {31'h0, core_o.push_level_bit3});
    chk("push nop", 1, {31'h0, core_o.nop_slot});
    do step(k); while (core_o.vec_fetch !== 1'b1);
    chk("entry cycles", 4 + stall, k);
    chk("vector", {25'h0, v}, {25'h0, core_o.vector_num});
    @(posedge hclk);
    chk("pc_load", 1, core_o.pc_load);
    chk("pc_value", {8'h0, 17'h00010, v}, {8'h0, core_o.pc_value});
  endtask : enter

  task automatic ret;
    int n;
    ret_go <= 1'b1;
    @(posedge hclk);
    ret_go <= 1'b0;
    n = 0;
    while (core_o.resume !== 1'b1) step(n);
    chk("return cycles", 5, n);
  endtask : ret

  task automatic convn(input logic p, input int e);
    int n;
    ext_pin[0] <= p;
    n = 0;
    repeat (10) @(posedge hclk) n += conv;
    chk("conv pulses", e, n);
  endtask : convn

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    {hresetn, hwrite, ret_go, stall, htrans, periph_req, ext_pin} = '0;
    {haddr, hwdata} = '0;
    n_fail = 0;
    checks = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_SOURCE_PRIORITY, 32'h44444444);
    rd(8'h40, 32'h0);
    bus(1'b1, OFS_REQUEST_ENABLE, 32'h2e);
    enter(8'h06, 7'h1, c0);
    rd(OFS_REQUEST_FLAG, 32'h06);
    lvl(3'h4);
    bus(1'b1, OFS_REQUEST_FLAG, 32'h0);
    bus(1'b1, OFS_SOURCE_PRIORITY, 32'h00604440);
    quiet(8'h08);
    enter(8'h20, 7'h5, c);
    lvl(3'h6);
    bus(1'b1, OFS_REQUEST_FLAG, 32'h0);
    ret();
    lvl(3'h4);
    ret();
    lvl(3'h0);
    bus(1'b1, OFS_INTERRUPT_CONTROL_ONE, 32'h8000);
    bus(1'b1, OFS_PROCESSOR_STATUS, 32'h60);
    lvl(3'h0);
    stall <= 1'b1;
    enter(8'h02, 7'h1, c);
    stall <= 1'b0;
    chk("stall latency", c0 + 1, c);
    lvl(3'h7);
    quiet(8'h20);
    bus(1'b1, OFS_REQUEST_FLAG, 32'h0);
    ret();
    bus(1'b1, OFS_INTERRUPT_CONTROL_ONE, 32'h0);
    bus(1'b1, OFS_PROCESSOR_STATUS, 32'he0);
    bus(1'b1, OFS_REQUEST_ENABLE, 32'h80);
    pulse(8'h80);
    repeat (4) @(posedge hclk);
    chk("wake", 0, wake);
    bus(1'b1, OFS_SOURCE_PRIORITY, 32'h20604440);
    repeat (3) @(posedge hclk);
    chk("wake", 1, wake);
    quiet(8'h0);
    bus(1'b1, OFS_REQUEST_FLAG, 32'h0);
    bus(1'b1, OFS_PROCESSOR_STATUS, 32'h0);
    bus(1'b1, OFS_REQUEST_ENABLE, 32'h0);
    convn(1'b1, 1);
    convn(1'b0, 0);
    bus(1'b1, OFS_INTERRUPT_CONTROL_TWO, 32'h1);
    convn(1'b1, 0);
    convn(1'b0, 1);
    rd(OFS_REQUEST_FLAG, 32'h1);
    give_verdict;
  end
endmodule : tb
